// ---- spm_pkg.sv ----
// constants shared by the self-programming controller, its cpu port and its page buffer
// assumes a single 100 MHz clock and a 16-bit pointer with a byte select in bit 0
package spm_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int OP_TIME_MIN_NS = 3_700_000;
  localparam int OP_TIME_MAX_NS = 4_500_000;
  localparam int OP_CYCLES_MIN  = (OP_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OP_CYCLES_MAX  = OP_TIME_MAX_NS / CLK_PERIOD_NS;
  localparam int TIMER_W        = 20;
  localparam int STORE_WINDOW   = 4;
  localparam int LOAD_WINDOW    = 3;
  localparam int ARM_W          = 3;
  localparam int LOAD_LAST      = STORE_WINDOW - LOAD_WINDOW + 1;

  // ****************************************************************
  // pointer layout and page buffer
  // ****************************************************************
  localparam int WORD_BITS = 4;
  localparam int ENTRIES   = 16;
  localparam int WORD_LSB  = 1;
  localparam int PAGE_LSB  = WORD_BITS + 1;
  localparam int PAGE_W    = 16 - PAGE_LSB;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ****************************************************************
  // control register
  // ****************************************************************
  localparam int BIT_CLEAR = 4;
  localparam int BIT_FUSE  = 3;
  localparam int BIT_WRITE = 2;
  localparam int BIT_ERASE = 1;
  localparam int BIT_EN    = 0;
  localparam logic [4:0] CTRL_RESET    = 5'h00;
  localparam logic [2:0] RESERVED_ZERO = 3'h0;
  localparam logic [4:0] CODE_CLEAR    = 5'h11;
  localparam logic [4:0] CODE_FUSE     = 5'h09;
  localparam logic [4:0] CODE_PAGE_WRITE_BIT    = 5'h05;
  localparam logic [4:0] CODE_PAGE_ERASE_BIT    = 5'h03;
  localparam logic [4:0] CODE_LOAD     = 5'h01;
  localparam logic [1:0] ZSEL_FUSE_LOW  = 2'h0;
  localparam logic [1:0] ZSEL_LOCK      = 2'h1;
  localparam logic [1:0] ZSEL_FUSE_HIGH = 2'h3;

  // ****************************************************************
  // cpu port registers and commands
  // ****************************************************************
  localparam logic [2:0] HREG_CMD    = 3'h0;
  localparam logic [2:0] HREG_ZPTR   = 3'h1;
  localparam logic [2:0] HREG_DATA   = 3'h2;
  localparam logic [2:0] HREG_STATUS = 3'h3;
  localparam logic [2:0] HREG_RESULT = 3'h4;
  localparam logic [2:0] OP_MAX      = 3'h4;
  typedef enum logic [2:0] {
    OP_LOAD_WORD,
    OP_ERASE,
    OP_WRITE,
    OP_CLEAR,
    OP_READ_FUSE
  } op_t;
endpackage

// ---- spm_link_if.sv ----
// link between the cpu core port and the self-programming controller
// assumes both ends share clk; every signal is driven by exactly one end
`timescale 1ns/1ns
`default_nettype none
interface spm_link_if;
  logic        ctrl_wr;
  logic [7:0]  ctrl_wdata;
  logic [7:0]  ctrl_rdata;
  logic        store_req;
  logic        load_req;
  logic [15:0] z_ptr;
  logic [15:0] data_pair;
  logic        load_valid;
  logic [7:0]  load_data;
  logic        cpu_halt;

  modport cpu (
    output ctrl_wr, ctrl_wdata, store_req, load_req, z_ptr, data_pair,
    input  ctrl_rdata, load_valid, load_data, cpu_halt
  );
  modport flash_ctrl (
    input  ctrl_wr, ctrl_wdata, store_req, load_req, z_ptr, data_pair,
    output ctrl_rdata, load_valid, load_data, cpu_halt
  );
endinterface
`default_nettype wire

// ---- page_buffer.sv ----
// temporary page buffer of the self-programming controller
// assumes the owner never writes and clears in the same cycle
`timescale 1ns/1ns
`default_nettype none
module page_buffer (
  input  wire logic                           clk,
  input  wire logic                           arst_n,
  input  wire logic                           clear,
  input  wire logic                           wr,
  input  wire logic [spm_pkg::WORD_BITS-1:0]  wr_idx,
  input  wire logic [15:0]                    wr_data,
  input  wire logic [spm_pkg::WORD_BITS-1:0]  rd_idx,
  output logic      [15:0]                    rd_data
);
  import spm_pkg::*;

  typedef struct packed {
    logic [ENTRIES-1:0][15:0] word;
    logic [15:0]              rd;
  } buf_state_t;

  buf_state_t s;
  buf_state_t next_s;

  // ****************************************************************
  // storage
  // ****************************************************************
  always_comb begin
    next_s = s;
    for (int i = 0; i < ENTRIES; i++) begin
      if (clear) begin
        next_s.word[i] = ERASED_WORD;
      end else if (wr && (wr_idx == WORD_BITS'(i))) begin
        next_s.word[i] = wr_data;
      end
    end
    // registered read costs the array one cycle of latency
    next_s.rd = s.word[rd_idx];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{word: {ENTRIES{ERASED_WORD}}, rd: ERASED_WORD};
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rd;
endmodule
`default_nettype wire

// ---- self_program_flash_ctrl.sv ----
// self-programming controller: control register, arming windows, page buffer, flash timing
// assumes eeprom_busy, sys_reset and the fuse bytes come from logic on clk
`timescale 1ns/1ns
`default_nettype none
module self_program_flash_ctrl #(
  parameter int OP_CYCLES = spm_pkg::OP_CYCLES_MIN
) (
  input  wire logic                           clk,
  input  wire logic                           arst_n,
  spm_link_if.flash_ctrl                      link,
  input  wire logic                           sys_reset,
  input  wire logic                           eeprom_busy,
  input  wire logic [7:0]                     fuse_low,
  input  wire logic [7:0]                     fuse_high,
  input  wire logic [7:0]                     lock_bits,
  output logic                                flash_start,
  output logic                                flash_erase,
  output logic                                flash_active,
  output logic      [spm_pkg::PAGE_W-1:0]     flash_page,
  input  wire logic [spm_pkg::WORD_BITS-1:0]  buf_rd_idx,
  output logic      [15:0]                    buf_rd_data
);
  import spm_pkg::*;

  typedef struct packed {
    logic [4:0]         ctrl;
    logic [ARM_W-1:0]   arm;
    logic               loaded;
    logic               busy;
    logic               erase;
    logic               clear_pend;
    logic [PAGE_W-1:0]  page;
    logic [TIMER_W-1:0] timer;
    logic               start;
    logic               load_valid;
    logic [7:0]         load_data;
  } dev_state_t;

  localparam dev_state_t DEV_RESET = '{
    ctrl: CTRL_RESET, arm: '0, loaded: 1'b0, busy: 1'b0, erase: 1'b0,
    clear_pend: 1'b0, page: '0, timer: '0, start: 1'b0, load_valid: 1'b0,
    load_data: '0
  };

  dev_state_t s;
  dev_state_t next_s;
  logic       buf_clear;
  logic       buf_wr;
  logic [7:0] fuse_sel;
  logic       enabled;

  // ****************************************************************
  // fuse and lock byte select
  // ****************************************************************
  always_comb begin
    // bytes pass through as stored, so programmed bits already read as zero
    case (link.z_ptr[1:0])
      ZSEL_LOCK:      fuse_sel = lock_bits;
      ZSEL_FUSE_HIGH: fuse_sel = fuse_high;
      ZSEL_FUSE_LOW:  fuse_sel = fuse_low;
      default:        fuse_sel = fuse_low;
    endcase
  end

  assign enabled = s.ctrl[BIT_EN] && (s.arm != '0);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    next_s            = s;
    next_s.start      = 1'b0;
    next_s.load_valid = 1'b0;
    buf_clear         = 1'b0;
    buf_wr            = 1'b0;
    if (s.busy) begin
      if (s.timer != '0) begin
        next_s.timer = s.timer - 1'b1;
      end else begin
        next_s.busy       = 1'b0;
        next_s.ctrl       = CTRL_RESET;
        next_s.clear_pend = 1'b0;
        if (!s.erase || s.clear_pend) begin
          buf_clear     = 1'b1;
          next_s.loaded = 1'b0;
        end
      end
    end else begin
      if (s.arm != '0) begin
        next_s.arm = s.arm - 1'b1;
      end
      if (s.arm == ARM_W'(1)) begin
        next_s.ctrl = CTRL_RESET;
      end
      if (s.ctrl[BIT_FUSE] && (s.arm == ARM_W'(LOAD_LAST))) begin
        next_s.ctrl = CTRL_RESET;
        next_s.arm  = '0;
      end
      if (link.load_req && enabled && s.ctrl[BIT_FUSE] && !eeprom_busy) begin
        next_s.load_valid = 1'b1;
        next_s.load_data  = fuse_sel;
        next_s.ctrl       = CTRL_RESET;
        next_s.arm        = '0;
      end
      // a store with the enable clear falls through untouched
      if (link.store_req && enabled && !eeprom_busy) begin
        next_s.ctrl = CTRL_RESET;
        next_s.arm  = '0;
        if (s.ctrl[BIT_ERASE] || s.ctrl[BIT_WRITE]) begin
          next_s.busy  = 1'b1;
          next_s.erase = s.ctrl[BIT_ERASE];
          next_s.page  = link.z_ptr[15:PAGE_LSB];
          next_s.timer = TIMER_W'(OP_CYCLES - 1);
          next_s.start = 1'b1;
          next_s.ctrl  = s.ctrl;
        end else if (!s.ctrl[BIT_FUSE]) begin
          // a second store to one word overwrites; software avoids it
          buf_wr        = 1'b1;
          next_s.loaded = 1'b1;
        end
      end
      if (link.ctrl_wr && !eeprom_busy) begin
        case (link.ctrl_wdata[4:0])
          CODE_CLEAR: begin
            buf_clear     = 1'b1;
            next_s.loaded = 1'b0;
            next_s.ctrl   = CTRL_RESET;
            next_s.arm    = '0;
          end
          CODE_FUSE, CODE_PAGE_WRITE_BIT, CODE_PAGE_ERASE_BIT, CODE_LOAD: begin
            next_s.ctrl = link.ctrl_wdata[4:0];
            next_s.arm  = ARM_W'(STORE_WINDOW);
          end
          default: begin
            next_s.ctrl = next_s.ctrl;
          end
        endcase
      end
    end
    if (eeprom_busy && s.loaded && !s.busy) begin
      buf_clear     = 1'b1;
      next_s.loaded = 1'b0;
    end
    if (sys_reset) begin
      next_s.arm        = '0;
      next_s.load_valid = 1'b0;
      // reset in the last busy cycle clears at once, leaving no stale pending clear
      if (s.busy && (s.timer != '0)) begin
        // the running operation keeps reading the buffer until it ends
        next_s.clear_pend = 1'b1;
      end else begin
        next_s.ctrl   = CTRL_RESET;
        next_s.loaded = 1'b0;
        buf_clear     = 1'b1;
        buf_wr        = 1'b0;
        next_s.busy   = 1'b0;
        next_s.start  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= DEV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // buffer and outputs
  // ****************************************************************
  page_buffer u_buffer (
    .clk     (clk),
    .arst_n  (arst_n),
    .clear   (buf_clear),
    .wr      (buf_wr),
    .wr_idx  (link.z_ptr[PAGE_LSB-1:WORD_LSB]),
    .wr_data (link.data_pair),
    .rd_idx  (buf_rd_idx),
    .rd_data (buf_rd_data)
  );

  assign link.ctrl_rdata = {RESERVED_ZERO, s.ctrl};
  assign link.cpu_halt   = s.busy;
  assign link.load_valid = s.load_valid;
  assign link.load_data  = s.load_data;
  assign flash_start     = s.start;
  assign flash_erase     = s.erase;
  assign flash_active    = s.busy;
  assign flash_page      = s.page;
endmodule
`default_nettype wire

// ---- spm_cpu_port.sv ----
// cpu-side end: turns register commands into control writes, stores and loads
// assumes a plain register port on clk with read data one cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
module spm_cpu_port (
  input  wire logic        clk,
  input  wire logic        arst_n,
  spm_link_if.cpu          link,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata
);
  import spm_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE,
    H_CTRL,
    H_EXEC,
    H_WAIT_OP,
    H_WAIT_LOAD
  } host_st_t;

  typedef struct packed {
    host_st_t    st;
    op_t         op;
    logic [4:0]  code;
    logic [15:0] z;
    logic [15:0] data;
    logic [7:0]  result;
    logic        result_ok;
    logic [15:0] rd;
  } host_state_t;

  host_state_t s;
  host_state_t next_s;
  logic        busy;

  function automatic logic [4:0] code_of(input op_t op);
    case (op)
      OP_LOAD_WORD: code_of = CODE_LOAD;
      OP_ERASE:     code_of = CODE_PAGE_ERASE_BIT;
      OP_WRITE:     code_of = CODE_PAGE_WRITE_BIT;
      OP_CLEAR:     code_of = CODE_CLEAR;
      OP_READ_FUSE: code_of = CODE_FUSE;
      default:      code_of = CTRL_RESET;
    endcase
  endfunction

  assign busy = (s.st != H_IDLE);

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_comb begin
    next_s = s;
    case (s.st)
      H_IDLE: begin
        if (wr && (addr == HREG_CMD) && (wdata[2:0] <= OP_MAX)) begin
          next_s.op        = op_t'(wdata[2:0]);
          next_s.code      = code_of(op_t'(wdata[2:0]));
          next_s.result_ok = 1'b0;
          next_s.st        = H_CTRL;
        end
      end
      H_CTRL: begin
        // store, or the load for a fuse read, follows the control write at once, well inside the window
        next_s.st = (s.op == OP_CLEAR) ? H_IDLE : H_EXEC;
      end
      H_EXEC: begin
        case (s.op)
          OP_ERASE, OP_WRITE: next_s.st = H_WAIT_OP;
          OP_READ_FUSE:       next_s.st = H_WAIT_LOAD;
          default:            next_s.st = H_IDLE;
        endcase
      end
      H_WAIT_OP: begin
        if (!link.cpu_halt) begin
          next_s.st = H_IDLE;
        end
      end
      H_WAIT_LOAD: begin
        // a blocked read never answers, so only one cycle is waited
        next_s.result    = link.load_data;
        next_s.result_ok = link.load_valid;
        next_s.st        = H_IDLE;
      end
      default: begin
        next_s.st = H_IDLE;
      end
    endcase
    if (wr && !busy && (addr == HREG_ZPTR)) begin
      next_s.z = wdata;
    end
    if (wr && !busy && (addr == HREG_DATA)) begin
      next_s.data = wdata;
    end
    next_s.rd = '0;
    if (rd) begin
      case (addr)
        HREG_ZPTR:   next_s.rd = s.z;
        HREG_DATA:   next_s.rd = s.data;
        HREG_STATUS: next_s.rd = {13'h0000, s.result_ok, link.cpu_halt, busy};
        HREG_RESULT: next_s.rd = {8'h00, s.result};
        default:     next_s.rd = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{st: H_IDLE, op: OP_LOAD_WORD, code: CTRL_RESET, z: '0, data: '0,
             result: '0, result_ok: 1'b0, rd: '0};
    end else begin
      s <= next_s;
    end
  end

  assign link.ctrl_wr    = (s.st == H_CTRL);
  assign link.ctrl_wdata = {RESERVED_ZERO, s.code};
  assign link.store_req  = (s.st == H_EXEC) && (s.op != OP_READ_FUSE);
  assign link.load_req   = (s.st == H_EXEC) && (s.op == OP_READ_FUSE);
  assign link.z_ptr      = s.z;
  assign link.data_pair  = s.data;
  assign rdata           = s.rd;
endmodule
`default_nettype wire

// ---- spm_link_asserts.sv ----
// checker on the link between the cpu port and the flash controller
// assumes OP_CYCLES equals the value given to the controller instance
`timescale 1ns/1ns
`default_nettype none
module spm_link_asserts #(
  parameter int OP_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic       store_req,
  input wire logic       load_req,
  input wire logic       load_valid,
  input wire logic       cpu_halt
);
  import spm_pkg::*;
  // ****************************************************************
  // halt length counter and properties
  // ****************************************************************
  int halt_cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      halt_cnt <= 0;
    else
      halt_cnt <= cpu_halt ? halt_cnt + 1 : 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_reserved_zero: assert property (ctrl_rdata[7:5] == RESERVED_ZERO)
    else $error("reserved control bits not zero");
  chk_erase_halts: assert property ((store_req && ctrl_rdata[4:0] == CODE_PAGE_ERASE_BIT && !cpu_halt)
    |=> cpu_halt) else $error("erase store did not halt cpu");
  chk_write_halts: assert property ((store_req && ctrl_rdata[4:0] == CODE_PAGE_WRITE_BIT && !cpu_halt)
    |=> cpu_halt [*8]) else $error("write store did not hold halt");
  chk_enable_held: assert property (cpu_halt |-> ctrl_rdata[BIT_EN])
    else $error("enable bit dropped during operation");
  chk_halt_length: assert property ($fell(cpu_halt) |-> halt_cnt == OP_CYCLES)
    else $error("flash operation length wrong");
  chk_load_disarm: assert property ((store_req && ctrl_rdata[4:0] == CODE_LOAD)
    |=> ctrl_rdata == 8'h00 && !cpu_halt) else $error("load store left control armed");
  chk_clear_noarm: assert property ((ctrl_wr && ctrl_wdata[4:0] == CODE_CLEAR && !cpu_halt)
    |=> ctrl_rdata == 8'h00) else $error("clear code left control armed");
  chk_load_cause: assert property (load_valid |-> $past(load_req))
    else $error("load answer without load");
  chk_fuse_answer: assert property ((load_req && ctrl_rdata[4:0] == CODE_FUSE)
    |=> load_valid ##1 ctrl_rdata[4:0] == 5'h00) else $error("fuse load not answered");
endmodule
`default_nettype wire

// ---- tb_self_program_flash_ctrl.sv ----
// testbench joining cpu port and flash controller over the link
// assumes a short operation count so each flash operation is quick
`timescale 1ns/1ns
`default_nettype none
module tb_self_program_flash_ctrl;
  import spm_pkg::*;
  localparam int OPC = 20;
  // ****************************************************************
  // signals, instances, monitor
  // ****************************************************************
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        sys_reset = 1'b0;
  logic        eeprom_busy = 1'b0;
  logic [7:0]  fuse_low = 8'h6a;
  logic [7:0]  fuse_high = 8'hd5;
  logic [7:0]  lock_bits = 8'hfc;
  logic        flash_start;
  logic        flash_erase;
  logic        flash_active;
  logic [10:0] flash_page;
  logic [3:0]  buf_rd_idx = 4'h0;
  logic [15:0] buf_rd_data;
  logic [27:0] cap = 28'h000_0000;
  int          bad_count = 0;
  int          n_checks = 0;
  int          run = 0;
  int          last_run = 0;
  int          starts = 0;
  always #5 clk = ~clk;
  spm_link_if link ();
  spm_cpu_port u_spm_cpu_port (.clk(clk), .arst_n(arst_n), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  self_program_flash_ctrl #(.OP_CYCLES(OPC)) u_self_program_flash_ctrl (.clk(clk),
    .arst_n(arst_n), .link(link), .sys_reset(sys_reset), .eeprom_busy(eeprom_busy),
    .fuse_low(fuse_low), .fuse_high(fuse_high), .lock_bits(lock_bits),
    .flash_start(flash_start), .flash_erase(flash_erase), .flash_active(flash_active),
    .flash_page(flash_page), .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data));
  spm_link_asserts #(.OP_CYCLES(OPC)) u_spm_link_asserts (.clk(clk), .arst_n(arst_n),
    .ctrl_wr(link.ctrl_wr), .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata),
    .store_req(link.store_req), .load_req(link.load_req), .load_valid(link.load_valid),
    .cpu_halt(link.cpu_halt));
  // operation length and first-cycle view of each flash operation
  always @(posedge clk) begin
    if (flash_active)
      run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
    if (flash_start) begin
      starts <= starts + 1;
      cap <= {flash_erase, flash_page, buf_rd_data};
    end
  end
  // ****************************************************************
  // bus tasks and scenarios
  // ****************************************************************
  task automatic chk(input string w, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // poll is bounded so a stuck command ends the run instead of hanging
  task automatic run_cmd(input logic [2:0] op, input logic [15:0] z, input logic [15:0] d);
    logic [15:0] s;
    reg_wr(HREG_ZPTR, z);
    reg_wr(HREG_DATA, d);
    reg_wr(HREG_CMD, {13'h0000, op});
    for (int i = 0; i < 200; i++) begin
      reg_rd(HREG_STATUS, s);
      if (s[1:0] === 2'b00)
        return;
    end
    bad_count++;
    end_sim();
  endtask
  task automatic buf_is(input logic [3:0] i, input logic [15:0] e, input string w);
    @(posedge clk);
    buf_rd_idx <= i;
    repeat (2) @(posedge clk);
    #1 chk(w, buf_rd_data, e);
  endtask
  task automatic t_reset();
    chk("ctrl after reset", {8'h00, link.ctrl_rdata}, 16'h0000);
    buf_is(4'h0, 16'hffff, "buffer after reset");
  endtask
  task automatic t_load_clear();
    run_cmd(OP_LOAD_WORD, 16'h0007, 16'h1234);
    buf_is(4'h3, 16'h1234, "loaded word");
    buf_is(4'h4, 16'hffff, "neighbour word");
    run_cmd(OP_CLEAR, 16'h0000, 16'h0000);
    buf_is(4'h3, 16'hffff, "cleared word");
  endtask
  task automatic t_eeprom();
    int s;
    logic [15:0] r;
    run_cmd(OP_LOAD_WORD, 16'h0004, 16'h5a5a);
    @(posedge clk);
    eeprom_busy <= 1'b1;
    buf_is(4'h2, 16'hffff, "word after eeprom write");
    s = starts;
    run_cmd(OP_ERASE, 16'h0020, 16'h0000);
    chk("starts while eeprom busy", 16'(starts), 16'(s));
    run_cmd(OP_READ_FUSE, 16'h0001, 16'h0000);
    reg_rd(HREG_STATUS, r);
    chk("fuse answer while eeprom busy", {15'h0000, r[2]}, 16'h0000);
    @(posedge clk);
    eeprom_busy <= 1'b0;
  endtask
  task automatic t_fuse();
    logic [15:0] r;
    logic [15:0] st;
    logic [15:0] zs [3];
    logic [15:0] ex [3];
    zs = '{16'h0000, 16'h0001, 16'h0003};
    ex = '{{8'h00, fuse_low}, {8'h00, lock_bits}, {8'h00, fuse_high}};
    for (int k = 0; k < 3; k++) begin
      run_cmd(OP_READ_FUSE, zs[k], 16'h0000);
      reg_rd(HREG_STATUS, st);
      chk("fuse answer flag", {15'h0000, st[2]}, 16'h0001);
      reg_rd(HREG_RESULT, r);
      chk("fuse or lock byte", {8'h00, r[7:0]}, ex[k]);
    end
  endtask
  task automatic t_write();
    int s;
    run_cmd(OP_LOAD_WORD, 16'h000a, 16'hbeef);
    buf_is(4'h5, 16'hbeef, "word before write");
    s = starts;
    run_cmd(OP_WRITE, 16'h00e0, 16'h0000);
    chk("write starts", 16'(starts), 16'(s + 1));
    chk("write mode page", {4'h0, cap[27:16]}, 16'h0007);
    chk("write data", cap[15:0], 16'hbeef);
    chk("write halt cycles", 16'(last_run), 16'(OPC));
    buf_is(4'h5, 16'hffff, "word after write");
  endtask
  task automatic t_erase_reset();
    run_cmd(OP_LOAD_WORD, 16'h0002, 16'h0f0f);
    @(posedge clk);
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
    buf_is(4'h1, 16'hffff, "word after system reset");
    run_cmd(OP_LOAD_WORD, 16'h0006, 16'h3c3c);
    // reset lands mid-erase: the operation must still run its full length
    fork
      run_cmd(OP_ERASE, 16'h0140, 16'h0000);
      begin
        repeat (14) @(posedge clk);
        sys_reset <= 1'b1;
        @(posedge clk);
        sys_reset <= 1'b0;
      end
    join
    chk("erase mode page", {4'h0, cap[27:16]}, 16'h080a);
    chk("erase halt cycles", 16'(last_run), 16'(OPC));
    // erase alone keeps the buffer, so only the deferred reset clear empties it
    buf_is(4'h3, 16'hffff, "word after reset during erase");
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_load_clear();
    t_eeprom();
    t_fuse();
    t_write();
    t_erase_reset();
    end_sim();
  end
endmodule
`default_nettype wire
